// File: tgf_consts.svh
// constants for the transmit gfc and nibble input ports
`ifndef TGF_CONSTS_SVH
`define TGF_CONSTS_SVH

`define TGF_CHANNELS      3
`define TGF_CLK_PERIOD_NS 10
`define TGF_PORT_HALF_NS  60
`define TGF_GFC_BITS      4
`define TGF_SYNC_W        15
`define TGF_PINS_PER_CH   5
`define TGF_POS_GFC       0
`define TGF_POS_NIB_LO    1
`define TGF_POS_NIB_B3    4

`endif

// File: tgf_pkg.sv
// types for the transmit gfc and nibble input ports
`include "tgf_consts.svh"

package tgf_pkg;

    typedef enum logic [2:0] {
        TGF_MODE_ATM_DIRECT,
        TGF_MODE_ATM_PLCP,
        TGF_MODE_CLEAR_NIBBLE,
        TGF_MODE_CLEAR_SERIAL,
        TGF_MODE_HDLC,
        TGF_MODE_PPP
    } tgf_mode_t;

    typedef struct packed {
        logic [3:0] div;
        logic       gfc_clk;
        logic       busy;
        logic [2:0] cnt;
        logic [3:0] shift;
        logic       marker;
        logic [3:0] gfc_value;
        logic       gfc_valid;
        logic [3:0] nib_div;
        logic       nib_clk;
        logic [3:0] nibble;
        logic       nib_valid;
        logic       pkt_bit3;
        logic       poh_en;
    } tgf_chan_t;

    typedef struct packed {
        tgf_chan_t [2:0] ch;
    } tgf_state_t;

    typedef struct packed {
        logic [`TGF_SYNC_W-1:0] s1;
        logic [`TGF_SYNC_W-1:0] s2;
        logic [`TGF_SYNC_W-1:0] s3;
        logic [`TGF_SYNC_W-1:0] out;
    } tgf_sync_t;

endpackage : tgf_pkg

// File: tgf_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "tgf_consts.svh"

module tgf_pin_sync (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // pins in, filtered levels out
    input  wire logic [`TGF_SYNC_W-1:0] pins,
    output logic      [`TGF_SYNC_W-1:0] levels
);

    tgf_pkg::tgf_sync_t q, d;

    always_comb begin
        d    = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // a bit only moves once the second and third stage agree
        for (int i = 0; i < `TGF_SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.out[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign levels = q.out;

endmodule : tgf_pin_sync

// File: tgf_tx_ports.sv
// transmit gfc serial port and nibble input for three channels
`timescale 1ns/1ps
`include "tgf_consts.svh"

module tgf_tx_ports (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // per-channel operating mode
    input  wire tgf_pkg::tgf_mode_t [2:0]      chan_mode,
    // gfc request from the cell builder, one-cycle pulse
    input  wire logic [2:0]                    gfc_fetch_start,
    // gfc serial port pins
    input  wire logic [2:0]                    gfc_serial_in,
    output logic      [2:0]                    gfc_demand_clock,
    output logic      [2:0]                    gfc_first_bit_marker,
    // captured gfc field
    output logic      [2:0][3:0]               gfc_value,
    output logic      [2:0]                    gfc_value_valid,
    // nibble input pins
    input  wire logic [2:0][2:0]               payload_nibble_low,
    input  wire logic [2:0]                    payload_nibble_bit3,
    output logic      [2:0]                    payload_nibble_clock,
    // sampled nibble and alternate pin meanings
    output logic      [2:0][3:0]               nibble_out,
    output logic      [2:0]                    nibble_valid,
    output logic      [2:0]                    packet_data_bit3,
    output logic      [2:0]                    path_overhead_insert_enable
);

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    // half period rounded down so the port clock is never slower than asked
    localparam int         HALF_CYC = (`TGF_PORT_HALF_NS / `TGF_CLK_PERIOD_NS) < 1 ? 1 :
                                      (`TGF_PORT_HALF_NS / `TGF_CLK_PERIOD_NS);
    localparam logic [3:0] HALF_M1  = 4'(HALF_CYC - 1);
    localparam logic [2:0] LAST_BIT = 3'(`TGF_GFC_BITS);

    function automatic logic is_atm(input tgf_pkg::tgf_mode_t m);
        return (m == tgf_pkg::TGF_MODE_ATM_DIRECT) || (m == tgf_pkg::TGF_MODE_ATM_PLCP);
    endfunction : is_atm

    function automatic logic nib_clk_on(input tgf_pkg::tgf_mode_t m);
        return (m == tgf_pkg::TGF_MODE_CLEAR_NIBBLE) || (m == tgf_pkg::TGF_MODE_HDLC);
    endfunction : nib_clk_on

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [`TGF_SYNC_W-1:0] pins;
    logic [`TGF_SYNC_W-1:0] sync;

    always_comb begin
        for (int c = 0; c < `TGF_CHANNELS; c++) begin
            pins[c*`TGF_PINS_PER_CH + `TGF_POS_GFC]         = gfc_serial_in[c];
            pins[c*`TGF_PINS_PER_CH + `TGF_POS_NIB_LO +: 3] = payload_nibble_low[c];
            pins[c*`TGF_PINS_PER_CH + `TGF_POS_NIB_B3]      = payload_nibble_bit3[c];
        end
    end

    tgf_pin_sync u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (pins),
        .levels  (sync)
    );

    // ------------------------------------------------------------
    // channel state
    // ------------------------------------------------------------
    tgf_pkg::tgf_state_t q, d;

    always_comb begin
        d = q;
        for (int c = 0; c < `TGF_CHANNELS; c++) begin
            d.ch[c].gfc_valid = 1'b0;
            d.ch[c].nib_valid = 1'b0;

            // gfc demand clock: runs only for a fetch in atm mode
            if (!is_atm(chan_mode[c])) begin
                d.ch[c].busy    = 1'b0;
                d.ch[c].gfc_clk = 1'b0;
                d.ch[c].div     = '0;
                d.ch[c].cnt     = '0;
            end else if (!q.ch[c].busy) begin
                if (gfc_fetch_start[c]) begin
                    d.ch[c].busy = 1'b1;
                    d.ch[c].div  = '0;
                    d.ch[c].cnt  = '0;
                end
            end else if (q.ch[c].div == HALF_M1) begin
                d.ch[c].div     = '0;
                d.ch[c].gfc_clk = ~q.ch[c].gfc_clk;
                if (!q.ch[c].gfc_clk) begin
                    // rising edge: the bit was set up on the previous fall, the first bit at marker start
                    d.ch[c].shift = {q.ch[c].shift[2:0],
                                     sync[c*`TGF_PINS_PER_CH + `TGF_POS_GFC]};
                    d.ch[c].cnt   = q.ch[c].cnt + 3'h1;
                    if (q.ch[c].cnt == LAST_BIT - 3'h1) begin
                        d.ch[c].gfc_value = {q.ch[c].shift[2:0],
                                             sync[c*`TGF_PINS_PER_CH + `TGF_POS_GFC]};
                        d.ch[c].gfc_valid = 1'b1;
                    end
                end else if (q.ch[c].cnt == LAST_BIT) begin
                    // finish on a fall so the far side sees a whole last period
                    d.ch[c].busy = 1'b0;
                end
            end else begin
                d.ch[c].div = q.ch[c].div + 4'h1;
            end
            // msb period: from fetch start until the first fall
            d.ch[c].marker = d.ch[c].busy && (d.ch[c].cnt == 3'h0 ||
                             (d.ch[c].cnt == 3'h1 && d.ch[c].gfc_clk));

            // nibble clock: free running in clear nibble and hdlc modes
            if (!nib_clk_on(chan_mode[c])) begin
                d.ch[c].nib_clk = 1'b0;
                d.ch[c].nib_div = '0;
            end else if (q.ch[c].nib_div == HALF_M1) begin
                d.ch[c].nib_div = '0;
                d.ch[c].nib_clk = ~q.ch[c].nib_clk;
                if (q.ch[c].nib_clk) begin
                    // falling edge: take all four bits in one go in clear nibble mode, bit 3 alone in hdlc
                    if (chan_mode[c] == tgf_pkg::TGF_MODE_CLEAR_NIBBLE) begin
                        d.ch[c].nibble    = {sync[c*`TGF_PINS_PER_CH + `TGF_POS_NIB_B3],
                                             sync[c*`TGF_PINS_PER_CH + `TGF_POS_NIB_LO +: 3]};
                        d.ch[c].nib_valid = 1'b1;
                    end else begin
                        d.ch[c].pkt_bit3  = sync[c*`TGF_PINS_PER_CH + `TGF_POS_NIB_B3];
                    end
                end
            end else begin
                d.ch[c].nib_div = q.ch[c].nib_div + 4'h1;
            end

            // overhead insert enable is a level, only meaningful in plcp mode
            d.ch[c].poh_en = (chan_mode[c] == tgf_pkg::TGF_MODE_ATM_PLCP) &&
                             sync[c*`TGF_PINS_PER_CH + `TGF_POS_NIB_B3];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < `TGF_CHANNELS; c++) begin
            gfc_demand_clock[c]            = q.ch[c].gfc_clk;
            gfc_first_bit_marker[c]        = q.ch[c].marker;
            gfc_value[c]                   = q.ch[c].gfc_value;
            gfc_value_valid[c]             = q.ch[c].gfc_valid;
            payload_nibble_clock[c]        = q.ch[c].nib_clk;
            nibble_out[c]                  = q.ch[c].nibble;
            nibble_valid[c]                = q.ch[c].nib_valid;
            packet_data_bit3[c]            = q.ch[c].pkt_bit3;
            path_overhead_insert_enable[c] = q.ch[c].poh_en;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_gfc_idle_0;
        !is_atm(chan_mode[0]) |=> !gfc_demand_clock[0];
    endproperty
    a_gfc_idle_0 : assert property (p_gfc_idle_0) else $error("demand clock out of atm");

    property p_gfc_idle_1;
        !is_atm(chan_mode[1]) |=> !gfc_demand_clock[1];
    endproperty
    a_gfc_idle_1 : assert property (p_gfc_idle_1) else $error("ch1 clock leaked");

    property p_gfc_high_width;
        ($rose(gfc_demand_clock[0]) ##0 is_atm(chan_mode[0])[*5])
            |-> gfc_demand_clock[0] ##1 gfc_demand_clock[0];
    endproperty
    a_gfc_high_width : assert property (p_gfc_high_width) else $error("demand high short");

    property p_marker_start;
        $rose(q.ch[0].busy) |-> gfc_first_bit_marker[0];
    endproperty
    a_marker_start : assert property (p_marker_start) else $error("marker missing");

    property p_marker_end;
        $fell(gfc_demand_clock[0]) && is_atm(chan_mode[0]) |-> !gfc_first_bit_marker[0];
    endproperty
    a_marker_end : assert property (p_marker_end) else $error("marker too long");

    property p_capture;
        $rose(gfc_demand_clock[0]) |-> q.ch[0].shift[0] == $past(sync[`TGF_POS_GFC]);
    endproperty
    a_capture : assert property (p_capture) else $error("gfc bit not captured");

    property p_field_done;
        $rose(q.ch[0].busy) && is_atm(chan_mode[0]) ##1 is_atm(chan_mode[0])[*8]
            |-> ##[1:60] gfc_value_valid[0];
    endproperty
    a_field_done : assert property (p_field_done) else $error("gfc field not done");

    property p_nib_sample;
        $fell(payload_nibble_clock[0]) && $past(chan_mode[0]) == tgf_pkg::TGF_MODE_CLEAR_NIBBLE
            |-> nibble_valid[0];
    endproperty
    a_nib_sample : assert property (p_nib_sample) else $error("nibble not sampled");

    property p_nib_bit3;
        nibble_valid[0] |-> nibble_out[0][3] == $past(sync[`TGF_POS_NIB_B3]);
    endproperty
    a_nib_bit3 : assert property (p_nib_bit3) else $error("nibble msb wrong");

    property p_poh;
        chan_mode[0] == tgf_pkg::TGF_MODE_ATM_PLCP
            |=> path_overhead_insert_enable[0] == $past(sync[`TGF_POS_NIB_B3]);
    endproperty
    a_poh : assert property (p_poh) else $error("overhead enable wrong");

endmodule : tgf_tx_ports

// File: tgf_far_end.sv
// far-end terminal model that feeds the gfc serial pins
`timescale 1ns/1ps

module tgf_far_end (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            reset_n,
    // gfc port of the device
    input  wire logic [2:0]      demand_clock,
    input  wire logic [2:0]      first_bit_marker,
    // field to send and the serial line
    input  wire logic [2:0][3:0] field,
    output logic      [2:0]      serial_out
);
    logic [2:0]      clk_q  = 3'h0;
    logic [2:0]      mk_q   = 3'h0;
    logic [2:0][2:0] left_q = '0;
    logic [2:0]      out_q  = 3'h0;

    assign serial_out = out_q;

    always @(posedge clk) begin
        for (int c = 0; c < 3; c++) begin
            clk_q[c] <= demand_clock[c];
            mk_q[c]  <= first_bit_marker[c];
            if (!reset_n) begin
                left_q[c] <= 3'h0;
                out_q[c]  <= 1'b0;
            end else if (first_bit_marker[c] && !mk_q[c]) begin
                out_q[c]  <= field[c][3];
                left_q[c] <= 3'h3;
            end else if (clk_q[c] && !demand_clock[c]) begin
                // after the last bit the line no longer holds its value
                if (left_q[c] != 3'h0) begin
                    out_q[c]  <= field[c][left_q[c] - 3'h1];
                    left_q[c] <= left_q[c] - 3'h1;
                end else begin
                    out_q[c] <= ~out_q[c];
                end
            end
        end
    end
endmodule : tgf_far_end

// File: tb_tgf_tx_ports.sv
// self-checking bench for the transmit gfc and nibble ports
`timescale 1ns/1ps

module tb_tgf_tx_ports;
    typedef struct packed {
        tgf_pkg::tgf_mode_t mode;
        logic [2:0][3:0]    field;
        logic [2:0][2:0]    low;
        logic [2:0]         b3;
    } tgf_row_t;

    logic                     clk     = 1'b0;
    logic                     reset_n = 1'b0;
    tgf_pkg::tgf_mode_t [2:0] chan_mode;
    logic [2:0]               fetch   = 3'h0;
    logic [2:0][3:0]          field   = '0;
    logic [2:0][2:0]          low     = '0;
    logic [2:0]               b3      = 3'h0;
    logic [2:0]               ser, dclk, mark, gval, nval, pkt, poh, dq;
    logic [2:0]               nck, nq;
    int                       falls [3];
    logic [2:0][3:0]          gv, nib;
    logic                     atm, nm, hd, pl;
    tgf_row_t                 r;
    int                       rises [3];
    int                       mk_hi [3];
    int                       vals [3];
    int                       nvs [3];
    int                       n_fail  = 0;
    int                       n_tests = 0;
    int                       cyc     = 0;
    tgf_row_t                 rows [8] = '{
        '{tgf_pkg::TGF_MODE_ATM_DIRECT,   12'h5a3, 9'h000, 3'h0},
        '{tgf_pkg::TGF_MODE_ATM_PLCP,     12'hf09, 9'h000, 3'h5},
        '{tgf_pkg::TGF_MODE_CLEAR_NIBBLE, 12'h000, 9'h1c6, 3'h6},
        '{tgf_pkg::TGF_MODE_CLEAR_SERIAL, 12'h000, 9'h1ff, 3'h7},
        '{tgf_pkg::TGF_MODE_HDLC,         12'h000, 9'h000, 3'h3},
        '{tgf_pkg::TGF_MODE_PPP,          12'h000, 9'h000, 3'h7},
        '{tgf_pkg::TGF_MODE_ATM_DIRECT,   12'h0f6, 9'h0aa, 3'h2},
        '{tgf_pkg::TGF_MODE_CLEAR_NIBBLE, 12'h000, 9'h039, 3'h1}};

    tgf_tx_ports u_dut (.clk(clk), .reset_n(reset_n), .chan_mode(chan_mode),
        .gfc_fetch_start(fetch), .gfc_serial_in(ser), .gfc_demand_clock(dclk),
        .gfc_first_bit_marker(mark), .gfc_value(gv), .gfc_value_valid(gval),
        .payload_nibble_low(low), .payload_nibble_bit3(b3),
        .payload_nibble_clock(nck), .nibble_out(nib), .nibble_valid(nval),
        .packet_data_bit3(pkt), .path_overhead_insert_enable(poh));

    tgf_far_end u_far (.clk(clk), .reset_n(reset_n), .demand_clock(dclk),
        .first_bit_marker(mark), .field(field), .serial_out(ser));

    initial forever #5 clk = ~clk;

    // ----------------------------------------
    // monitor on the falling edge, outputs settled
    // ----------------------------------------
    always @(negedge clk) begin
        for (int c = 0; c < 3; c++) begin
            dq[c] <= dclk[c];
            nq[c] <= nck[c];
            if (dclk[c] && !dq[c]) rises[c]++;
            if (!nck[c] && nq[c]) falls[c]++;
            if (dclk[c] && mark[c]) mk_hi[c]++;
            if (gval[c]) vals[c]++;
            if (nval[c]) nvs[c]++;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 1500) begin
            n_fail++;
            summarize();
        end
    end

    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic apply(tgf_row_t a);
        @(posedge clk);
        for (int c = 0; c < 3; c++) chan_mode[c] <= a.mode;
        field <= a.field;
        low <= a.low;
        b3 <= a.b3;
        repeat (8) @(posedge clk);
    endtask : apply

    task automatic window(logic [2:0] go, int n);
        for (int c = 0; c < 3; c++) begin
            rises[c] = 0;
            mk_hi[c] = 0;
            vals[c] = 0;
            nvs[c] = 0;
            falls[c] = 0;
        end
        @(posedge clk);
        fetch <= go;
        @(posedge clk);
        fetch <= 3'h0;
        repeat (n) @(posedge clk);
    endtask : window

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int c = 0; c < 3; c++) chan_mode[c] = tgf_pkg::TGF_MODE_PPP;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            r = rows[i];
            atm = (r.mode <= tgf_pkg::TGF_MODE_ATM_PLCP);
            nm = (r.mode == tgf_pkg::TGF_MODE_CLEAR_NIBBLE);
            hd = (r.mode == tgf_pkg::TGF_MODE_HDLC);
            pl = (r.mode == tgf_pkg::TGF_MODE_ATM_PLCP);
            apply(r);
            // fetch is offered in every mode; only atm may answer it
            window(3'h7, 62);
            for (int c = 0; c < 3; c++) begin
                check("demand rises", atm ? 4'h4 : 4'h0, 4'(rises[c]));
                check("marker with clock high", atm ? 4'h6 : 4'h0, 4'(mk_hi[c]));
                check("gfc valid count", {3'h0, atm}, 4'(vals[c]));
                if (atm) check("gfc value", r.field[c], gv[c]);
                check("nibble seen", {3'h0, nm}, {3'h0, nvs[c] != 0});
                check("nibble clock runs", {3'h0, nm | hd}, {3'h0, falls[c] != 0});
                check("sample per fall", nm ? 4'(falls[c]) : 4'h0, 4'(nvs[c]));
                if (nm) check("nibble value", {r.b3[c], r.low[c]}, nib[c]);
                if (hd) check("packet bit3", {3'h0, r.b3[c]}, {3'h0, pkt[c]});
                check("overhead enable", {3'h0, pl & r.b3[c]}, {3'h0, poh[c]});
            end
            $display("test row %0d done", i);
        end
        // mixed modes, refetch while busy, abort by leaving atm
        apply('{tgf_pkg::TGF_MODE_ATM_DIRECT, 12'h6c9, 9'h0f5, 3'h2});
        chan_mode[1] <= tgf_pkg::TGF_MODE_CLEAR_NIBBLE;
        chan_mode[2] <= tgf_pkg::TGF_MODE_ATM_PLCP;
        repeat (8) @(posedge clk);
        window(3'h5, 20);
        fetch <= 3'h1;
        chan_mode[2] <= tgf_pkg::TGF_MODE_PPP;
        @(posedge clk);
        fetch <= 3'h0;
        repeat (45) @(posedge clk);
        check("ch0 rises", 4'h4, 4'(rises[0]));
        check("ch0 value", 4'h9, gv[0]);
        check("ch2 valid count", 4'h0, 4'(vals[2]));
        check("ch2 demand clock", 4'h0, {3'h0, dclk[2]});
        check("ch1 rises", 4'h0, 4'(rises[1]));
        check("ch1 nibble", {b3[1], low[1]}, nib[1]);
        $display("test mixed done");
        // reset in mid-field, then a clean field
        window(3'h1, 10);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("demand clock in reset", 4'h0, {1'b0, dclk});
        check("marker in reset", 4'h0, {1'b0, mark});
        @(posedge clk);
        reset_n <= 1'b1;
        apply(rows[0]);
        window(3'h7, 62);
        for (int c = 0; c < 3; c++) begin
            check("value after reset", rows[0].field[c], gv[c]);
        end
        $display("test reset done");
        summarize();
    end
endmodule : tb_tgf_tx_ports
